/* File: rtl/accel_cfg_pkg.sv */
// Purpose : constants for the accelerometer configuration register bank
// Assumes : byte-wide registers behind the serial interface logic
// Notes   : offsets are the serial register addresses
`default_nettype none
package accel_cfg_pkg;
   // -------------------------------------------------------------------
   // register addresses
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_IDENTITY   = 8'h0F;
   localparam logic [7:0] ADDR_ACT_THR    = 8'h1E;
   localparam logic [7:0] ADDR_ACT_DUR    = 8'h1F;
   localparam logic [7:0] ADDR_RATE_AXIS  = 8'h20;
   localparam logic [7:0] ADDR_FILTER     = 8'h21;
   localparam logic [7:0] ADDR_FIFO_IRQ   = 8'h22;
   localparam logic [7:0] ADDR_BW_IFACE   = 8'h23;
   localparam logic [7:0] ADDR_RST_PIN    = 8'h24;
   localparam logic [7:0] ADDR_OUT_FIRST  = 8'h28;
   localparam logic [7:0] ADDR_OUT_LAST   = 8'h2D;
   // -------------------------------------------------------------------
   // reset values and writable masks
   // -------------------------------------------------------------------
   localparam logic [7:0] RST_ZERO        = 8'h00;
   localparam logic [7:0] RST_RATE_AXIS   = 8'h07;
   localparam logic [7:0] RST_BW_IFACE    = 8'h04;
   localparam logic [7:0] MASK_ALL        = 8'hFF;
   localparam logic [7:0] MASK_LOW7       = 8'h7F;
   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int B_HIGH_RES   = 7;
   localparam int B_RATE_HI    = 6;
   localparam int B_RATE_LO    = 4;
   localparam int B_BLOCK_UPD  = 3;
   localparam int B_Z_ON       = 2;
   localparam int B_Y_ON       = 1;
   localparam int B_X_ON       = 0;
   localparam int B_CUT_HI     = 6;
   localparam int B_CUT_LO     = 5;
   localparam int B_HPM_HI     = 4;
   localparam int B_HPM_LO     = 3;
   localparam int B_FDS        = 2;
   localparam int B_HP_GEN2    = 1;
   localparam int B_HP_GEN1    = 0;
   localparam int B_FIFO_EN    = 7;
   localparam int B_LEVEL_USE  = 6;
   localparam int B_ROUTE_HI   = 5;
   localparam int B_ROUTE_LO   = 0;
   localparam int B_BW_HI      = 7;
   localparam int B_BW_LO      = 6;
   localparam int B_RANGE_HI   = 5;
   localparam int B_RANGE_LO   = 4;
   localparam int B_BW_MANUAL  = 3;
   localparam int B_AUTO_INC   = 2;
   localparam int B_I2C_OFF    = 1;
   localparam int B_SPI_READ   = 0;
   localparam int B_DEBUG      = 7;
   localparam int B_SOFT_RST   = 6;
   localparam int B_DEC_HI     = 5;
   localparam int B_DEC_LO     = 4;
   localparam int B_ST_HI      = 3;
   localparam int B_ST_LO      = 2;
   localparam int B_IRQ_POL    = 1;
   localparam int B_IRQ_DRV    = 0;
   // -------------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      RATE_OFF, RATE_10, RATE_50, RATE_100,
      RATE_200, RATE_400, RATE_800, RATE_BAD
   } rate_e;
   localparam logic [1:0] BW_400 = 2'h0;
   localparam logic [1:0] BW_200 = 2'h1;
   localparam logic [1:0] BW_100 = 2'h2;
   localparam logic [1:0] BW_50  = 2'h3;
   localparam logic [8:0] DIV_NONE = 9'h000;
   localparam logic [8:0] DIV_50   = 9'h032;
   localparam logic [8:0] DIV_100  = 9'h064;
   localparam logic [8:0] DIV_9    = 9'h009;
   localparam logic [8:0] DIV_400  = 9'h190;
   localparam logic [1:0] HPM_REF  = 2'h1;
   localparam logic [1:0] HPM_NA   = 2'h3;
endpackage
`default_nettype wire

/* File: rtl/accel_config_register_bank.sv */
// Purpose : accelerometer configuration registers and their decoded controls
// Assumes : serial interface logic in the same clock domain issues one
//           access_start per transfer and one byte strobe per data byte
// Notes   : outputs are registered; decoded controls lag a write by a cycle, effective_bw and lp_cutoff_div by two
`default_nettype none
// Function
// - read-only identity code at 0Fh, writes ignored
// - threshold: seven writable bits, resets zero
// - duration byte read/write, resets zero
// - rate code: off, 10..800 Hz, 111 invalid
// - block update holds outputs until both bytes read
// - high resolution selects cutoff divider by field
// - three axis enables, reset to one
// - high-pass mode 00/10 normal, 01 reference
// - filtered-data bit feeds filter to outputs
// - per-generator high-pass insertion bits
// - queue enable and level use, reset zero
// - six routing bits onto interrupt pin
// - bandwidth field 400/200/100/50 Hz
// - range 2g/4g/8g, code 01 unavailable
// - automatic bandwidth follows rate when scaling clear
// - manual bandwidth except at 50/10 Hz
// - auto-increment advances address per byte
// - SPI reads allowed only when mode bit set
// - control five field layout from debug down
// - soft reset acts as power-on, self-clears
// - decimation refreshes every 1/2/4/8 samples
// - pin polarity and push-pull/open-drain driver
module accel_config_register_bank
   import accel_cfg_pkg::*;
#(
   parameter logic [7:0] IDENTITY_CODE = 8'h5A  // arbitrary value
) (
   // clock and reset
   input  wire  logic       core_clk,
   input  wire  logic       reset_n,
   // access from serial interface logic
   input  wire  logic       access_start,
   input  wire  logic [7:0] start_addr,
   input  wire  logic       access_is_spi,
   input  wire  logic       byte_wr,
   input  wire  logic [7:0] byte_wr_data,
   input  wire  logic       byte_rd,
   output logic [7:0]       byte_rd_data,
   output logic             byte_rd_valid,
   output logic             byte_rd_refused,
   output logic [7:0]       access_addr,
   // sensing datapath events
   input  wire  logic       sample_tick,
   input  wire  logic [5:0] irq_sources,
   // decoded controls
   output logic             high_resolution,
   output logic [2:0]       sample_rate_sel,
   output logic             power_down,
   output logic             rate_invalid,
   output logic             z_axis_on,
   output logic             y_axis_on,
   output logic             x_axis_on,
   output logic [8:0]       lp_cutoff_div,
   output logic [1:0]       highpass_mode,
   output logic             highpass_reference,
   output logic             filtered_data_sel,
   output logic [1:0]       highpass_for_irq_gen,
   output logic             queue_enable,
   output logic             queue_level_use,
   output logic [1:0]       effective_bw,
   output logic [1:0]       range_sel,
   output logic             i2c_enable,
   output logic             debug_step,
   output logic [1:0]       selftest_sel,
   output logic             output_refresh,
   output logic [7:0]       activity_level,
   output logic [7:0]       activity_duration,
   // interrupt pin
   output logic             accel_irq_pin_o,
   output logic             accel_irq_pin_oe
);

   // --------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] act_thr;
      logic [7:0] act_dur;
      logic [7:0] rate_axis;
      logic [7:0] filter;
      logic [7:0] fifo_irq;
      logic [7:0] bw_iface;
      logic [7:0] rst_pin;
      logic [7:0] ptr;
      logic       ptr_spi;
      logic [7:0] rd_data;
      logic       rd_valid;
      logic       rd_refused;
      logic       soft_rst;
      logic [2:0] dec_cnt;
      logic       lo_read;
      logic       hi_read;
      logic       refresh;
      logic [1:0] bw_eff;
      logic [8:0] cut_div;
      logic       irq_o;
      logic       irq_oe;
   } bank_s;

   bank_s state_reg;
   bank_s state_next;

   // --------------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------------
   function automatic logic [1:0] auto_bw(input logic [2:0] rate);
      case (rate)
         RATE_400: auto_bw = BW_200;
         RATE_200: auto_bw = BW_100;
         RATE_100: auto_bw = BW_50;
         default:  auto_bw = BW_400;
      endcase
   endfunction

   function automatic logic [7:0] read_reg(input bank_s s,
                                           input logic [7:0] a);
      case (a)
         ADDR_IDENTITY:  read_reg = IDENTITY_CODE;
         ADDR_ACT_THR:   read_reg = s.act_thr & MASK_LOW7;
         ADDR_ACT_DUR:   read_reg = s.act_dur;
         ADDR_RATE_AXIS: read_reg = s.rate_axis;
         ADDR_FILTER:    read_reg = s.filter & MASK_LOW7;
         ADDR_FIFO_IRQ:  read_reg = s.fifo_irq;
         ADDR_BW_IFACE:  read_reg = s.bw_iface;
         ADDR_RST_PIN:   read_reg = s.rst_pin;
         default:        read_reg = RST_ZERO;
      endcase
   endfunction

   function automatic logic [2:0] dec_last(input logic [1:0] d);
      case (d)
         2'h0:    dec_last = 3'h0;
         2'h1:    dec_last = 3'h1;
         2'h2:    dec_last = 3'h3;
         default: dec_last = 3'h7;
      endcase
   endfunction

   // --------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------
   logic       bus_ok;
   logic       out_addr;
   logic       is_lo;
   logic [7:0] wmask;
   logic [2:0] rate;
   logic       any_irq;

   always_comb begin
      state_next            = state_reg;
      state_next.rd_valid   = 1'b0;
      state_next.rd_refused = 1'b0;
      state_next.refresh    = 1'b0;
      state_next.soft_rst   = 1'b0;
      rate    = state_reg.rate_axis[B_RATE_HI:B_RATE_LO];
      // accesses over I2C are dropped while it is disabled
      bus_ok  = state_reg.ptr_spi
                | ~state_reg.bw_iface[B_I2C_OFF];
      out_addr = (state_reg.ptr >= ADDR_OUT_FIRST)
                 && (state_reg.ptr <= ADDR_OUT_LAST);
      is_lo   = ~state_reg.ptr[0];
      case (state_reg.ptr)
         ADDR_ACT_THR: wmask = MASK_LOW7;
         ADDR_FILTER:  wmask = MASK_LOW7;
         default:      wmask = MASK_ALL;
      endcase

      if (access_start) begin
         state_next.ptr     = start_addr;
         state_next.ptr_spi = access_is_spi;
      end else if ((byte_wr || byte_rd) && bus_ok) begin
         if (state_reg.bw_iface[B_AUTO_INC]) begin
            state_next.ptr = state_reg.ptr + 8'h01;
         end
      end

      if (byte_wr && bus_ok && !access_start) begin
         case (state_reg.ptr)
            ADDR_ACT_THR:   state_next.act_thr = byte_wr_data & wmask;
            ADDR_ACT_DUR:   state_next.act_dur = byte_wr_data;
            ADDR_RATE_AXIS: state_next.rate_axis = byte_wr_data;
            ADDR_FILTER:    state_next.filter = byte_wr_data & wmask;
            ADDR_FIFO_IRQ:  state_next.fifo_irq = byte_wr_data;
            ADDR_BW_IFACE:  state_next.bw_iface = byte_wr_data;
            ADDR_RST_PIN: begin
               // soft reset never stored; it only arms a one-cycle pulse
               state_next.rst_pin = byte_wr_data;
               state_next.rst_pin[B_SOFT_RST] = 1'b0;
               state_next.soft_rst = byte_wr_data[B_SOFT_RST];
            end
            default: ;  // identity and unmapped ignore writes
         endcase
      end

      // decimation and block-update gating of output refresh
      if (sample_tick && rate != RATE_OFF) begin
         if (state_reg.dec_cnt
             >= dec_last(state_reg.rst_pin[B_DEC_HI:B_DEC_LO])) begin
            state_next.dec_cnt = 3'h0;
            if (!state_reg.rate_axis[B_BLOCK_UPD]
                || (state_reg.lo_read && state_reg.hi_read)) begin
               state_next.refresh = 1'b1;
               state_next.lo_read = 1'b0;
               state_next.hi_read = 1'b0;
            end
         end else begin
            state_next.dec_cnt = state_reg.dec_cnt + 3'h1;
         end
      end

      // after the refresh clear, so a read in that cycle still counts
      if (byte_rd && bus_ok && !access_start) begin
         if (state_reg.ptr_spi && !state_reg.bw_iface[B_SPI_READ]) begin
            state_next.rd_refused = 1'b1;
            state_next.rd_data    = RST_ZERO;
         end else begin
            state_next.rd_valid = 1'b1;
            state_next.rd_data  = read_reg(state_reg, state_reg.ptr);
            if (out_addr) begin
               if (is_lo) state_next.lo_read = 1'b1;
               else       state_next.hi_read = 1'b1;
            end
         end
      end

      // bandwidth selection
      if (!state_reg.bw_iface[B_BW_MANUAL]) begin
         state_next.bw_eff = auto_bw(rate);
      end else if (rate == RATE_50 || rate == RATE_10) begin
         state_next.bw_eff = BW_400;
      end else begin
         state_next.bw_eff = state_reg.bw_iface[B_BW_HI:B_BW_LO];
      end

      // low-pass cutoff divider in high-resolution mode
      if (!state_reg.rate_axis[B_HIGH_RES]) begin
         state_next.cut_div = DIV_NONE;
      end else begin
         case (state_reg.filter[B_CUT_HI:B_CUT_LO])
            2'h0:    state_next.cut_div = DIV_50;
            2'h1:    state_next.cut_div = DIV_100;
            2'h2:    state_next.cut_div = DIV_9;
            default: state_next.cut_div = DIV_400;
         endcase
      end

      // interrupt pin: routed sources, polarity and driver type
      any_irq = |(irq_sources
                  & state_reg.fifo_irq[B_ROUTE_HI:B_ROUTE_LO]);
      state_next.irq_o  = any_irq ^ state_reg.rst_pin[B_IRQ_POL];
      state_next.irq_oe = ~state_reg.rst_pin[B_IRQ_DRV] | any_irq;

      // soft reset returns every control to its power-on value
      if (state_reg.soft_rst) begin
         state_next.act_thr   = RST_ZERO;
         state_next.act_dur   = RST_ZERO;
         state_next.rate_axis = RST_RATE_AXIS;
         state_next.filter    = RST_ZERO;
         state_next.fifo_irq  = RST_ZERO;
         state_next.bw_iface  = RST_BW_IFACE;
         state_next.rst_pin   = RST_ZERO;
         state_next.dec_cnt   = 3'h0;
         state_next.lo_read   = 1'b0;
         state_next.hi_read   = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg           <= '0;
         state_reg.rate_axis <= RST_RATE_AXIS;
         state_reg.bw_iface  <= RST_BW_IFACE;
         state_reg.irq_oe    <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // --------------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------------
   assign byte_rd_data       = state_reg.rd_data;
   assign byte_rd_valid      = state_reg.rd_valid;
   assign byte_rd_refused    = state_reg.rd_refused;
   assign access_addr        = state_reg.ptr;
   assign high_resolution    = state_reg.rate_axis[B_HIGH_RES];
   assign sample_rate_sel    = state_reg.rate_axis[B_RATE_HI:B_RATE_LO];
   assign power_down         = (sample_rate_sel == RATE_OFF);
   assign rate_invalid       = (sample_rate_sel == RATE_BAD);
   assign z_axis_on          = state_reg.rate_axis[B_Z_ON];
   assign y_axis_on          = state_reg.rate_axis[B_Y_ON];
   assign x_axis_on          = state_reg.rate_axis[B_X_ON];
   assign lp_cutoff_div      = state_reg.cut_div;
   assign highpass_mode      = state_reg.filter[B_HPM_HI:B_HPM_LO];
   assign highpass_reference = (highpass_mode == HPM_REF);
   assign filtered_data_sel  = state_reg.filter[B_FDS];
   assign highpass_for_irq_gen =
      state_reg.filter[B_HP_GEN2:B_HP_GEN1];
   assign queue_enable       = state_reg.fifo_irq[B_FIFO_EN];
   assign queue_level_use    = state_reg.fifo_irq[B_LEVEL_USE];
   assign effective_bw       = state_reg.bw_eff;
   assign range_sel          =
      state_reg.bw_iface[B_RANGE_HI:B_RANGE_LO];
   assign i2c_enable         = ~state_reg.bw_iface[B_I2C_OFF];
   assign debug_step         = state_reg.rst_pin[B_DEBUG];
   assign selftest_sel       = state_reg.rst_pin[B_ST_HI:B_ST_LO];
   assign output_refresh     = state_reg.refresh;
   assign activity_level     = state_reg.act_thr;
   assign activity_duration  = state_reg.act_dur;
   assign accel_irq_pin_o    = state_reg.irq_o;
   assign accel_irq_pin_oe   = state_reg.irq_oe;

   // --------------------------------------------------------------------
   // checks
   // --------------------------------------------------------------------
   property p_identity;
      @(posedge core_clk) disable iff (!reset_n)
      byte_rd && !access_start && state_reg.ptr == ADDR_IDENTITY
      && !state_reg.ptr_spi && i2c_enable
      |=> byte_rd_valid && byte_rd_data == IDENTITY_CODE;
   endproperty
   a_identity: assert property (p_identity)
      else $error("identity read wrong");

   property p_thr_top;
      @(posedge core_clk) disable iff (!reset_n)
      activity_level[7] == 1'b0;
   endproperty
   a_thr_top: assert property (p_thr_top)
      else $error("threshold top bit set");

   property p_spi_refuse;
      @(posedge core_clk) disable iff (!reset_n)
      byte_rd && !access_start && state_reg.ptr_spi
      && !state_reg.bw_iface[B_SPI_READ]
      |=> byte_rd_refused && !byte_rd_valid;
   endproperty
   a_spi_refuse: assert property (p_spi_refuse)
      else $error("spi read not refused");

   property p_autoinc;
      @(posedge core_clk) disable iff (!reset_n)
      byte_wr && !access_start && state_reg.ptr_spi
      && state_reg.ptr != ADDR_BW_IFACE && state_reg.ptr != ADDR_RST_PIN
      && !state_reg.soft_rst
      |=> access_addr == $past(access_addr)
          + {7'h00, $past(state_reg.bw_iface[B_AUTO_INC])};
   endproperty
   a_autoinc: assert property (p_autoinc)
      else $error("address advance wrong");

   property p_soft_rst;
      @(posedge core_clk) disable iff (!reset_n)
      byte_wr && !access_start && bus_ok && state_reg.ptr == ADDR_RST_PIN
      && byte_wr_data[B_SOFT_RST]
      |=> !state_reg.rst_pin[B_SOFT_RST]
      ##1 state_reg.rate_axis == RST_RATE_AXIS && activity_level == RST_ZERO;
   endproperty
   a_soft_rst: assert property (p_soft_rst)
      else $error("soft reset did not restore");

   property p_bw_fixed;
      @(posedge core_clk) disable iff (!reset_n)
      (sample_rate_sel == RATE_50 || sample_rate_sel == RATE_10)
      && $stable(sample_rate_sel) |=> effective_bw == BW_400;
   endproperty
   a_bw_fixed: assert property (p_bw_fixed)
      else $error("bandwidth not fixed at low rate");

   property p_bw_auto;
      @(posedge core_clk) disable iff (!reset_n)
      sample_rate_sel == RATE_400 && !state_reg.bw_iface[B_BW_MANUAL]
      |=> effective_bw == BW_200;
   endproperty
   a_bw_auto: assert property (p_bw_auto)
      else $error("automatic bandwidth wrong");

   property p_block;
      @(posedge core_clk) disable iff (!reset_n)
      output_refresh && $past(state_reg.rate_axis[B_BLOCK_UPD])
      |-> $past(state_reg.lo_read) && $past(state_reg.hi_read);
   endproperty
   a_block: assert property (p_block)
      else $error("refresh while pair unread");

   property p_irq_pol;
      @(posedge core_clk) disable iff (!reset_n)
      $stable(state_reg.rst_pin) && $stable(state_reg.fifo_irq)
      && (irq_sources & state_reg.fifo_irq[B_ROUTE_HI:B_ROUTE_LO]) == '0
      |=> accel_irq_pin_o == $past(state_reg.rst_pin[B_IRQ_POL]);
   endproperty
   a_irq_pol: assert property (p_irq_pol)
      else $error("idle pin level wrong");

endmodule
`default_nettype wire

/* File: testbench/host_model.sv */
// Purpose : host side of the register access port
// Assumes : one clock; strobes move 1 ns after the rising edge
// Notes   : a released data bus shows the inverse of the last byte
`default_nettype none
module host_model (
   // clock
   input  wire  logic       core_clk,
   // access strobes
   output logic             access_start,
   output logic [7:0]       start_addr,
   output logic             access_is_spi,
   output logic             byte_wr,
   output logic [7:0]       byte_wr_data,
   output logic             byte_rd,
   // read answer
   input  wire  logic [7:0] byte_rd_data,
   input  wire  logic       byte_rd_valid,
   input  wire  logic       byte_rd_refused
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {access_start, access_is_spi, byte_wr, byte_rd} = 4'h0;
      start_addr = 8'h00;
      byte_wr_data = 8'h00;
   end
   task automatic start(input logic [7:0] a, input logic spi);
      @(posedge core_clk);
      #1 access_start = 1'b1;
      start_addr = a;
      access_is_spi = spi;
      @(posedge core_clk);
      #1 access_start = 1'b0;
      start_addr = ~a;
   endtask
   // answer is sampled in the one cycle it stands
   task automatic xfer(input logic wr, input logic [7:0] d,
                       output logic [7:0] q, output logic v, f);
      @(posedge core_clk);
      #1 byte_wr = wr;
      byte_rd = !wr;
      byte_wr_data = d;
      @(posedge core_clk);
      #1 byte_wr = 1'b0;
      byte_rd = 1'b0;
      byte_wr_data = ~d;
      q = byte_rd_data;
      v = byte_rd_valid;
      f = byte_rd_refused;
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose : self-checking bench for the configuration register bank
// Assumes : host_model issues every access
// Notes   : a byte-array model predicts every read and decode
`default_nettype none
module testbench;
   import accel_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ID = 8'hA5;  // arbitrary value
   logic core_clk, reset_n, access_start, access_is_spi, byte_wr, byte_rd;
   logic [7:0] start_addr, byte_wr_data, byte_rd_data, a, d;
   logic byte_rd_valid, byte_rd_refused, power_down, rate_invalid, hit;
   logic i2c_enable, accel_irq_pin_o, accel_irq_pin_oe, output_refresh;
   wire [17:0] fld;
   wire [15:0] act;
   logic [1:0] effective_bw, range_sel;
   logic [8:0] lp_cutoff_div;
   logic [5:0] irq_sources;
   logic sample_tick = 1'b0;
   logic [7:0] mdl [256];
   logic [7:0] amap [9] = '{8'h0F, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22,
                            8'h23, 8'h24, 8'h10};
   int err_count = 0, n_tests = 0, cyc = 0, n_ref = 0;
   logic [31:0] rnd = 32'h0000_1B36;

   accel_config_register_bank #(.IDENTITY_CODE(ID)) u_dut (
      .core_clk, .reset_n, .access_start, .start_addr, .access_is_spi,
      .byte_wr, .byte_wr_data, .byte_rd, .byte_rd_data, .byte_rd_valid,
      .byte_rd_refused, .access_addr(), .sample_tick, .irq_sources,
      .high_resolution(fld[6]), .sample_rate_sel(fld[5:3]), .power_down,
      .rate_invalid, .z_axis_on(fld[2]), .y_axis_on(fld[1]),
      .x_axis_on(fld[0]), .lp_cutoff_div, .highpass_mode(fld[12:11]),
      .highpass_reference(fld[10]), .filtered_data_sel(fld[9]),
      .highpass_for_irq_gen(fld[8:7]), .queue_enable(fld[14]),
      .queue_level_use(fld[13]), .effective_bw, .range_sel, .i2c_enable,
      .debug_step(fld[17]), .selftest_sel(fld[16:15]), .output_refresh,
      .activity_level(act[7:0]), .activity_duration(act[15:8]),
      .accel_irq_pin_o, .accel_irq_pin_oe);
   host_model u_host (
      .core_clk, .access_start, .start_addr, .access_is_spi, .byte_wr,
      .byte_wr_data, .byte_rd, .byte_rd_data, .byte_rd_valid,
      .byte_rd_refused);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // ceiling well above the thousand or so cycles the run needs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      n_ref <= n_ref + int'(output_refresh);
      sample_tick <= #1 (cyc[2:0] == 3'h0);
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end

   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] wmask(logic [7:0] x);
      case (x)
         8'h1E, 8'h21: return 8'h7F;
         8'h1F, 8'h20, 8'h22, 8'h23: return 8'hFF;
         8'h24: return 8'hBF;
         default: return 8'h00;
      endcase
   endfunction
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rst_mdl();
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[8'h0F] = ID;
      mdl[8'h20] = 8'h07;
      mdl[8'h23] = 8'h04;
   endtask
   task automatic rd(input logic [7:0] x, input logic spi);
      logic [7:0] q;
      logic v, f, deny;
      deny = spi && !mdl[8'h23][0];
      u_host.start(x, spi);
      u_host.xfer(1'b0, 8'h00, q, v, f);
      chk({7'h0, v, f}, {7'h0, !deny, deny});
      chk({1'b0, q}, deny ? 9'h000 : {1'b0, mdl[x]});
   endtask
   task automatic all_rd(input logic spi);
      foreach (amap[i]) rd(amap[i], spi);
   endtask
   // pointer moves only on accepted bytes
   task automatic wr(input logic [7:0] x, input logic spi,
                     input logic [7:0] q[$]);
      logic [7:0] p, r;
      logic v, f;
      p = x;
      u_host.start(x, spi);
      foreach (q[i]) begin
         u_host.xfer(1'b1, q[i], r, v, f);
         if (spi || !mdl[8'h23][1]) begin
            mdl[p] = (mdl[p] & ~wmask(p)) | (q[i] & wmask(p));
            if (mdl[8'h23][2]) p++;
         end
      end
   endtask
   task automatic dec_chk();
      logic [2:0] r;
      logic [1:0] bw;
      logic [8:0] dv;
      r = mdl[8'h20][6:4];
      bw = BW_400;
      if (mdl[8'h23][3] && !(r inside {3'h1, 3'h2}))
         bw = mdl[8'h23][7:6];
      else if (r == 3'h3) bw = BW_50;
      else if (r == 3'h4) bw = BW_100;
      else if (r == 3'h5) bw = BW_200;
      case (mdl[8'h21][6:5])
         2'h0: dv = DIV_50;
         2'h1: dv = DIV_100;
         2'h2: dv = DIV_9;
         default: dv = DIV_400;
      endcase
      if (!mdl[8'h20][7]) dv = DIV_NONE;
      chk({i2c_enable, power_down, rate_invalid, effective_bw},
          {!mdl[8'h23][1], r == 3'h0, r == 3'h7, bw});
      chk(lp_cutoff_div, dv);
      chk({7'h0, range_sel}, {7'h0, mdl[8'h23][5:4]});
      chk(fld, {mdl[8'h24][7], mdl[8'h24][3:2], mdl[8'h22][7:6],
                mdl[8'h21][4:3], mdl[8'h21][4:3] == 2'h1, mdl[8'h21][2:0],
                mdl[8'h20][7:4], mdl[8'h20][2:0]});
      chk(act, {mdl[8'h1F], mdl[8'h1E]});
   endtask
   // refresh pulses over a window of 160 cycles, 20 sample ticks
   task automatic ref_chk(input int exp);
      int c;
      @(posedge core_clk);
      #1 c = n_ref;
      repeat (160) @(posedge core_clk);
      #1 chk(n_ref - c, exp);
   endtask

   initial begin
      irq_sources = 6'h00;
      rst_mdl();
      reset_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 reset_n = 1'b1;
      all_rd(1'b0);
      rd(8'h20, 1'b1);
      dec_chk();
      wr(8'h0F, 1'b0, '{8'hFF});
      for (int k = 0; k < 40; k++) begin
         rnd = xs(rnd);
         a = amap[rnd[3:0] % 9];
         d = rnd[15:8];
         // host keeps clear of reserved codes, soft reset and I2C disable, and keeps auto-increment on
         if (a == 8'h20 && d[6:4] == 3'h7) d[6] = 1'b0;
         if (a == 8'h23 && d[5:4] == 2'h1) d[4] = 1'b0;
         if (a == 8'h21 && d[4:3] == 2'h3) d[4] = 1'b0;
         if (a == 8'h23) d[2:1] = 2'h2;
         if (a == 8'h24) d[6] = 1'b0;
         wr(a, rnd[16], '{d});
         rd(a, rnd[17]);
         dec_chk();
      end
      wr(8'h23, 1'b0, '{8'h01});
      wr(8'h1E, 1'b0, '{8'h92, 8'h34});
      wr(8'h23, 1'b0, '{8'h05});
      wr(8'h1E, 1'b1, '{8'h56, 8'h78});
      all_rd(1'b1);
      wr(8'h23, 1'b0, '{8'h07});
      wr(8'h1F, 1'b0, '{8'hC3});
      dec_chk();
      rd(8'h1F, 1'b1);
      wr(8'h23, 1'b1, '{8'h05});
      for (int k = 0; k < 4; k++) begin
         rnd = xs(rnd);
         wr(8'h22, 1'b1, '{{2'h0, rnd[5:0]}});
         wr(8'h24, 1'b1, '{{6'h0, k[1:0]}});
         irq_sources = rnd[13:8];
         repeat (2) @(posedge core_clk);
         #1 hit = |(rnd[13:8] & rnd[5:0]);
         chk({7'h0, accel_irq_pin_o, accel_irq_pin_oe},
             {7'h0, hit ^ k[1], !k[0] || hit});
      end
      wr(8'h24, 1'b1, '{8'h40});
      repeat (3) @(posedge core_clk);
      rst_mdl();
      all_rd(1'b0);
      dec_chk();
      wr(8'h24, 1'b0, '{8'h10});
      wr(8'h20, 1'b0, '{8'h17});
      ref_chk(10);
      wr(8'h20, 1'b0, '{8'h1F});
      ref_chk(0);
      rd(8'h28, 1'b0);
      rd(8'h29, 1'b0);
      ref_chk(1);
      test_done();
   end
endmodule
`default_nettype wire
